// >>> core/smx_pkg.sv
// package: constants and types for the move/io instruction executor
// Behaviour
// - opcode bit meaning flips with role
// - move needs connection, in either role
// - target drives phase lines from field
// - command group sets descriptor length count
// - vendor groups obey vendor unique enable
// - kept zero count in groups 3 and 4 raises illegal interrupt
// - target chained receive parks odd byte
// - target atn or parity halts, now or later
// - initiator waits unserviced req, latches phase
// - initiator chained parks odd byte either way
// - mismatch interrupts, match transfers count
// - message out drops atn on last handshake
// - message in leaves ack asserted at end
// - phase codes in ascending binary order
// - count down, address up, then fetch
// - start address, indirect, table indirect fetches
// - io opcode map per role
// - reselect arbitrates, retries, fetches on win
// - selected before win jumps alternate
// - target disconnect releases all scsi outputs
// - wait select continue or jump alternate
// - set clear ack atn role carry
// - target set clear leaves bus alone
// - table address is base plus offset
package smx_pkg;

  // ****************************************
  // register offsets (plain port)
  // ****************************************
  localparam logic [3:0] SMX_ADDR_CMD = 4'h0;
  localparam logic [3:0] SMX_ADDR_ARG = 4'h1;
  localparam logic [3:0] SMX_ADDR_COUNT = 4'h2;
  localparam logic [3:0] SMX_ADDR_NEXT = 4'h3;
  localparam logic [3:0] SMX_ADDR_BASE = 4'h4;
  localparam logic [3:0] SMX_ADDR_CTRL = 4'h5;
  localparam logic [3:0] SMX_ADDR_STATUS = 4'h6;
  localparam logic [3:0] SMX_ADDR_RESID = 4'h7;
  localparam logic [3:0] SMX_ADDR_OWNID = 4'h8;
  localparam logic [3:0] SMX_ADDR_FETCH = 4'h9;

  // control register bit positions
  localparam int SMX_CTL_GO = 0;
  localparam int SMX_CTL_VUE = 1;
  localparam int SMX_CTL_NOHALT = 2;
  localparam int SMX_CTL_TARGET = 3;
  localparam int SMX_CTL_SIGNAL_PROCESS_BIT = 4;
  localparam int SMX_CTL_CARRY = 5;
  localparam int SMX_CTL_ACK = 6;
  localparam int SMX_CTL_ATN = 7;
  localparam int SMX_CTL_SELATN = 8;

  // status bit positions (status register low byte)
  localparam int SMX_ST_BUSY = 0;
  localparam int SMX_ST_ILLEGAL = 1;
  localparam int SMX_ST_MISMATCH = 2;
  localparam int SMX_ST_HALT = 3;
  localparam int SMX_ST_ALT = 4;
  localparam int SMX_ST_FETCH = 5;

  // instruction fields
  localparam int SMX_TYPE_HI = 31;
  localparam int SMX_IND_BIT = 29;
  localparam int SMX_TBL_BIT = 28;
  localparam int SMX_OPC_BIT = 27;
  localparam int SMX_PHASE_LO = 24;
  localparam int SMX_IOOP_LO = 27;
  localparam int SMX_ACK_BIT = 6;
  localparam int SMX_ATN_BIT = 3;
  localparam int SMX_ROLE_BIT = 9;
  localparam int SMX_CARRY_BIT = 10;
  localparam int SMX_DEST_LO = 16;

  localparam logic [1:0] SMX_TYPE_MOVE = 2'h0;
  localparam logic [1:0] SMX_TYPE_IO = 2'h1;
  localparam logic [31:0] SMX_RESET_WORD = 32'h0000_0000;
  localparam logic [23:0] SMX_COUNT_ZERO = 24'h00_0000;
  localparam logic [23:0] SMX_CDB6 = 24'h00_0006;
  localparam logic [23:0] SMX_CDB10 = 24'h00_000a;
  localparam logic [23:0] SMX_CDB12 = 24'h00_000c;

  typedef enum logic [2:0] {
    SMX_PH_DOUT = 3'h0,
    SMX_PH_DIN = 3'h1,
    SMX_PH_CMD = 3'h2,
    SMX_PH_STAT = 3'h3,
    SMX_PH_RSVO = 3'h4,
    SMX_PH_RSVI = 3'h5,
    SMX_PH_MOUT = 3'h6,
    SMX_PH_MIN = 3'h7
  } smx_phase_t;

  typedef enum logic [2:0] {
    SMX_IO_RESEL = 3'h0,
    SMX_IO_DISC = 3'h1,
    SMX_IO_WSEL = 3'h2,
    SMX_IO_SET = 3'h3,
    SMX_IO_CLR = 3'h4
  } smx_ioop_t;

endpackage : smx_pkg

// >>> core/smx_bus_if.sv
// interface: byte stream between executor and mover
`timescale 1ns/1ns
`default_nettype none
interface smx_bus_if;
  logic req;
  logic send;
  logic done;
  logic odd;
  logic [7:0] last_byte;
  logic [7:0] first_byte;
  logic first_valid;
  modport exec (output req, output send, input done, input odd, input last_byte,
    input first_byte, input first_valid);
  modport mover (input req, input send, output done, output odd, output last_byte,
    output first_byte, output first_valid);
endinterface : smx_bus_if
`default_nettype wire

// >>> core/smx_cdb_len.sv
// command group decoder: descriptor length from first command byte
`timescale 1ns/1ns
`default_nettype none
module smx_cdb_len (
  // command byte and mode
  input wire logic [7:0] cmd_byte,
  input wire logic vue,
  input wire logic [23:0] prog_count,
  // result
  output logic [23:0] count,
  output logic illegal
);
  import smx_pkg::*;
  logic [2:0] grp;
  always_comb begin
    grp = cmd_byte[7:5];
    count = prog_count;
    illegal = 1'b0;
    case (grp)
      3'h0: count = SMX_CDB6;
      3'h1, 3'h2: count = SMX_CDB10;
      3'h5: count = SMX_CDB12;
      3'h6, 3'h7: begin
        // vendor groups take a six byte block unless enabled
        if (!vue) begin
          count = SMX_CDB6;
        end
      end
      default: begin
        illegal = (prog_count == SMX_COUNT_ZERO);
      end
    endcase
    if (vue && (grp == 3'h6 || grp == 3'h7)) begin
      illegal = 1'b0;
    end
  end
endmodule : smx_cdb_len
`default_nettype wire

// >>> core/smx_mover.sv
// byte mover: counts the bytes of a move up to its count and reports odd end and first byte
`timescale 1ns/1ns
`default_nettype none
module smx_mover (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // byte side
  input wire logic byte_stb,
  input wire logic [7:0] byte_data,
  input wire logic [23:0] count,
  input wire logic wide,
  // executor side
  smx_bus_if.mover bus
);
  import smx_pkg::*;
  typedef struct packed {
    logic [23:0] seen;
    logic [7:0] last;
    logic [7:0] first;
    logic fv;
    logic done;
  } smx_mv_t;
  smx_mv_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!bus.req) begin
      s_d.seen = SMX_COUNT_ZERO;
      s_d.fv = 1'b0;
    end else if (byte_stb && !s_q.done) begin
      s_d.seen = s_q.seen + 24'h00_0001;
      s_d.last = byte_data;
      if (!s_q.fv) begin
        s_d.first = byte_data;
        s_d.fv = 1'b1;
      end
      if (s_q.seen + 24'h00_0001 >= count) begin
        s_d.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign bus.done = s_q.done;
  assign bus.odd = wide & s_q.seen[0];
  assign bus.last_byte = s_q.last;
  assign bus.first_byte = s_q.first;
  assign bus.first_valid = s_q.fv;
endmodule : smx_mover
`default_nettype wire

// >>> core/smx_exec.sv
// move and io instruction executor, top level
`timescale 1ns/1ns
`default_nettype none
module smx_exec (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // fetched word port from memory side
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_data,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  // data path byte stream
  input wire logic byte_stb,
  input wire logic [7:0] byte_data,
  input wire logic wide,
  input wire logic parity_err,
  // scsi bus state, from pins
  input wire logic msg_line_in,
  input wire logic cd_line_in,
  input wire logic io_line_in,
  input wire logic req_line_in,
  input wire logic ack_line_in,
  input wire logic atn_line_in,
  input wire logic connected_in,
  input wire logic selected_in,
  input wire logic reselected_in,
  input wire logic arb_won_in,
  input wire logic arb_lost_in,
  // scsi drive
  output logic msg_line_out,
  output logic cd_line_out,
  output logic io_line_out,
  output logic ack_line_out,
  output logic atn_line_out,
  output logic drive_oe,
  output logic arb_req,
  output logic [3:0] arb_dest
);
  import smx_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] sy1_q, sy2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else if (ce) begin
      sy1_q <= {msg_line_in, cd_line_in, io_line_in, req_line_in, ack_line_in, atn_line_in,
        connected_in, selected_in, reselected_in, arb_won_in, arb_lost_in};
      sy2_q <= sy1_q;
    end
  end
  logic [2:0] bus_phase;
  logic s_req, s_ack, s_atn, s_conn, s_sel, s_resel, s_won, s_lost;
  assign bus_phase = sy2_q[10:8];
  assign s_req = sy2_q[7];
  assign s_ack = sy2_q[6];
  assign s_atn = sy2_q[5];
  assign s_conn = sy2_q[4];
  assign s_sel = sy2_q[3];
  assign s_resel = sy2_q[2];
  assign s_won = sy2_q[1];
  assign s_lost = sy2_q[0];

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    SMX_IDLE = 4'h0,
    SMX_DECODE = 4'h1,
    SMX_FETCH1 = 4'h2,
    SMX_FETCH2 = 4'h3,
    SMX_WAITPH = 4'h4,
    SMX_CMDBYTE = 4'h5,
    SMX_XFER = 4'h6,
    SMX_ARB = 4'h7,
    SMX_WSEL = 4'h8,
    SMX_NEXT = 4'h9
  } smx_state_t;

  typedef struct packed {
    smx_state_t st;
    logic [31:0] cmd;
    logic [31:0] arg;
    logic [23:0] count;
    logic [31:0] next_addr;
    logic [31:0] base;
    logic [8:0] ctrl;
    logic [7:0] status;
    logic [7:0] resid;
    logic [7:0] out_latch;
    logic [3:0] own_id;
    logic [2:0] phase_latch;
    logic [7:0] rdata;
    logic chained;
    logic halt_pend;
  } smx_state_s_t;
  smx_state_s_t s_q, s_d;

  smx_bus_if bus ();
  logic [23:0] cdb_count;
  logic cdb_illegal;
  logic is_target;

  smx_cdb_len u_cdb (
    .cmd_byte(byte_data),
    .vue(s_q.ctrl[SMX_CTL_VUE]),
    .prog_count(s_q.count),
    .count(cdb_count),
    .illegal(cdb_illegal)
  );

  smx_mover u_mover (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .byte_stb(byte_stb),
    .byte_data(byte_data),
    .count((s_q.st == SMX_CMDBYTE) ? cdb_count : s_q.count),
    .wide(wide),
    .bus(bus.mover)
  );

  // sign extended table offset added to structure base
  function automatic logic [31:0] smx_tbl_addr(input logic [31:0] b, input logic [23:0] off);
    smx_tbl_addr = b + {{8{off[23]}}, off};
  endfunction : smx_tbl_addr

  assign is_target = s_q.ctrl[SMX_CTL_TARGET];

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    s_d = s_q;
    bus.req = (s_q.st == SMX_XFER) || (s_q.st == SMX_CMDBYTE);
    bus.send = is_target ? s_q.cmd[SMX_PHASE_LO] : ~s_q.cmd[SMX_PHASE_LO];
    // register writes
    if (reg_wr) begin
      if (reg_addr == SMX_ADDR_CMD) begin
        s_d.cmd = reg_wdata;
      end else if (reg_addr == SMX_ADDR_ARG) begin
        s_d.arg = reg_wdata;
      end else if (reg_addr == SMX_ADDR_COUNT) begin
        s_d.count = reg_wdata[23:0];
      end else if (reg_addr == SMX_ADDR_NEXT) begin
        s_d.next_addr = reg_wdata;
      end else if (reg_addr == SMX_ADDR_BASE) begin
        s_d.base = reg_wdata;
      end else if (reg_addr == SMX_ADDR_CTRL) begin
        s_d.ctrl = reg_wdata[8:0];
      end else if (reg_addr == SMX_ADDR_STATUS) begin
        s_d.status = s_q.status & ~reg_wdata[7:0];
      end else if (reg_addr == SMX_ADDR_OWNID) begin
        s_d.own_id = reg_wdata[3:0];
      end
    end
    // register reads, data a cycle later
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == SMX_ADDR_STATUS) begin
        s_d.rdata = {s_q.status[7:3], s_q.phase_latch};
      end else if (reg_addr == SMX_ADDR_RESID) begin
        s_d.rdata = s_q.resid;
      end else if (reg_addr == SMX_ADDR_CTRL) begin
        s_d.rdata = s_q.ctrl[7:0];
      end
    end
    case (s_q.st)
      SMX_IDLE: begin
        if (s_q.ctrl[SMX_CTL_GO]) begin
          s_d.ctrl[SMX_CTL_GO] = 1'b0;
          s_d.status[SMX_ST_BUSY] = 1'b1;
          s_d.st = SMX_DECODE;
        end
      end
      SMX_DECODE: begin
        if (s_q.cmd[SMX_TYPE_HI:30] == SMX_TYPE_MOVE) begin
          // opcode meaning flips with role
          s_d.chained = is_target ? s_q.cmd[SMX_OPC_BIT] : ~s_q.cmd[SMX_OPC_BIT];
          s_d.next_addr = s_q.arg;
          if (!s_q.cmd[SMX_TBL_BIT]) begin
            s_d.count = s_q.cmd[23:0];
          end
          if (!s_conn) begin
            s_d.status[SMX_ST_ILLEGAL] = 1'b1;
            s_d.st = SMX_IDLE;
          end else if (s_q.cmd[SMX_TBL_BIT] || s_q.cmd[SMX_IND_BIT]) begin
            s_d.st = SMX_FETCH1;
          end else begin
            s_d.st = SMX_WAITPH;
          end
        end else begin
          case (s_q.cmd[29:27])
            SMX_IO_RESEL: begin
              if (is_target) begin
                s_d.st = SMX_ARB;
              end else begin
                s_d.st = SMX_NEXT;
              end
            end
            SMX_IO_DISC: begin
              if (is_target) begin
                s_d.ctrl[SMX_CTL_ACK] = 1'b0;
                s_d.ctrl[SMX_CTL_ATN] = 1'b0;
              end
              s_d.st = SMX_NEXT;
            end
            SMX_IO_WSEL: begin
              s_d.st = is_target ? SMX_WSEL : SMX_NEXT;
            end
            SMX_IO_SET, SMX_IO_CLR: begin
              // flags in the instruction pick which bits change
              if (s_q.cmd[SMX_ACK_BIT]) begin
                s_d.ctrl[SMX_CTL_ACK] = (s_q.cmd[29:27] == SMX_IO_SET);
              end
              if (s_q.cmd[SMX_ATN_BIT]) begin
                s_d.ctrl[SMX_CTL_ATN] = (s_q.cmd[29:27] == SMX_IO_SET);
              end
              if (s_q.cmd[SMX_ROLE_BIT]) begin
                s_d.ctrl[SMX_CTL_TARGET] = (s_q.cmd[29:27] == SMX_IO_SET);
              end
              if (s_q.cmd[SMX_CARRY_BIT]) begin
                s_d.ctrl[SMX_CTL_CARRY] = (s_q.cmd[29:27] == SMX_IO_SET);
              end
              s_d.st = SMX_NEXT;
            end
            default: begin
              s_d.st = SMX_NEXT; // remaining codes go straight to the next fetch
            end
          endcase
        end
      end
      SMX_FETCH1: begin
        if (fetch_valid) begin
          if (s_q.cmd[SMX_TBL_BIT]) begin
            s_d.count = fetch_data[23:0];
            s_d.st = SMX_FETCH2;
          end else begin
            s_d.next_addr = fetch_data;
            s_d.st = SMX_WAITPH;
          end
        end
      end
      SMX_FETCH2: begin
        if (fetch_valid) begin
          s_d.next_addr = fetch_data;
          s_d.st = SMX_WAITPH;
        end
      end
      SMX_WAITPH: begin
        if (is_target) begin
          s_d.st = (s_q.cmd[26:24] == SMX_PH_CMD) ? SMX_CMDBYTE : SMX_XFER;
        end else if (s_req && !s_ack) begin
          s_d.phase_latch = bus_phase;
          if (bus_phase != s_q.cmd[26:24]) begin
            s_d.status[SMX_ST_MISMATCH] = 1'b1;
            s_d.st = SMX_IDLE;
          end else begin
            s_d.st = SMX_XFER;
          end
        end
      end
      SMX_CMDBYTE: begin
        if (byte_stb) begin
          s_d.count = cdb_count;
          if (cdb_illegal) begin
            s_d.status[SMX_ST_ILLEGAL] = 1'b1;
            s_d.st = SMX_IDLE;
          end else begin
            s_d.st = SMX_XFER;
          end
        end
      end
      SMX_XFER: begin
        if (is_target && (s_atn || parity_err)) begin
          s_d.halt_pend = 1'b1;
        end
        if (is_target && (s_atn || parity_err) && !s_q.ctrl[SMX_CTL_NOHALT]) begin
          s_d.status[SMX_ST_HALT] = 1'b1;
          s_d.halt_pend = 1'b0;
          s_d.st = SMX_IDLE;
        end else if (bus.done) begin
          s_d.next_addr = s_q.next_addr + {8'h00, s_q.count};
          s_d.count = SMX_COUNT_ZERO;
          if (s_q.chained && bus.odd) begin
            if (!bus.send) begin
              s_d.resid = bus.last_byte;
            end else if (!is_target) begin
              s_d.out_latch = bus.last_byte;
            end
          end
          if (!is_target && s_q.cmd[26:24] == SMX_PH_MOUT) begin
            s_d.ctrl[SMX_CTL_ATN] = 1'b0;
          end
          if (!is_target && s_q.cmd[26:24] == SMX_PH_MIN) begin
            s_d.ctrl[SMX_CTL_ACK] = 1'b1;
          end
          if (s_q.halt_pend || (is_target && (s_atn || parity_err))) begin
            s_d.status[SMX_ST_HALT] = 1'b1;
            s_d.halt_pend = 1'b0;
            s_d.st = SMX_IDLE;
          end else begin
            s_d.st = SMX_NEXT;
          end
        end
      end
      SMX_ARB: begin
        if (s_sel || s_resel) begin
          s_d.status[SMX_ST_ALT] = 1'b1;
          s_d.st = SMX_NEXT;
        end else if (s_won) begin
          s_d.st = SMX_NEXT;
        end
      end
      SMX_WSEL: begin
        if (s_sel) begin
          s_d.st = SMX_NEXT;
        end else if (s_resel || s_q.ctrl[SMX_CTL_SIGNAL_PROCESS_BIT]) begin
          s_d.ctrl[SMX_CTL_SIGNAL_PROCESS_BIT] = 1'b0;
          s_d.status[SMX_ST_ALT] = 1'b1;
          s_d.st = SMX_NEXT;
        end
      end
      SMX_NEXT: begin
        s_d.status[SMX_ST_FETCH] = 1'b1;
        s_d.status[SMX_ST_BUSY] = 1'b0;
        s_d.st = SMX_IDLE;
      end
      default: begin
        s_d.st = SMX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = {24'h00_0000, s_q.rdata};
  assign fetch_req = (s_q.st == SMX_FETCH1) || (s_q.st == SMX_FETCH2);
  assign fetch_addr = s_q.cmd[SMX_TBL_BIT]
    ? smx_tbl_addr(s_q.base, s_q.arg[23:0]) + ((s_q.st == SMX_FETCH2) ? 32'h4 : 32'h0)
    : s_q.arg;
  // initiator-only lines gated off in target role
  assign msg_line_out = s_q.cmd[26];
  assign cd_line_out = s_q.cmd[25];
  assign io_line_out = s_q.cmd[24];
  assign drive_oe = is_target && s_conn && (s_q.st == SMX_XFER || s_q.st == SMX_CMDBYTE);
  assign ack_line_out = s_q.ctrl[SMX_CTL_ACK] & ~is_target;
  assign atn_line_out = s_q.ctrl[SMX_CTL_ATN] & ~is_target;
  assign arb_req = (s_q.st == SMX_ARB) && !s_lost;
  assign arb_dest = (s_q.st == SMX_ARB) ? s_q.cmd[SMX_DEST_LO +: 4] : s_q.own_id;
endmodule : smx_exec
`default_nettype wire

// >>> sim/smx_exec_checker.sv
// checker: executor port properties
`timescale 1ns/1ns
`default_nettype none
module smx_exec_checker (
  // clock, reset, register port
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // fetch and scsi side
  input wire logic fetch_valid,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic arb_won_in,
  input wire logic msg_line_out,
  input wire logic cd_line_out,
  input wire logic io_line_out,
  input wire logic ack_line_out,
  input wire logic atn_line_out,
  input wire logic drive_oe,
  input wire logic arb_req,
  input wire logic [3:0] arb_dest
);
  import smx_pkg::*;
  // ****************
  // command shadow
  // ****************
  logic [31:0] cmd_q, cmd_d;
  assign cmd_d = (reg_wr && reg_addr == SMX_ADDR_CMD) ? reg_wdata : cmd_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= 32'h0;
    end else begin
      cmd_q <= cmd_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence ctl_wr_s;
    reg_wr && reg_addr == SMX_ADDR_CTRL;
  endsequence
  sequence disc_go_s;
    ctl_wr_s ##0 (reg_wdata[SMX_CTL_GO] && cmd_q[31:27] == 5'h09);
  endsequence
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("stray read data");
  phase_drive_a: assert property (
    drive_oe |-> {msg_line_out, cd_line_out, io_line_out} == cmd_q[26:24])
    else $error("bad phase");
  tgt_gate_a: assert property (drive_oe |-> !ack_line_out && !atn_line_out)
    else $error("target ack atn");
  arb_dest_a: assert property (arb_req |-> arb_dest == cmd_q[19:16])
    else $error("bad dest id");
  arb_stop_a: assert property ($rose(arb_won_in) && arb_req |-> ##[1:6] !arb_req)
    else $error("arb after win");
  disc_release_a: assert property (
    disc_go_s |-> ##[2:12] (!drive_oe && !arb_req && !ack_line_out && !atn_line_out))
    else $error("disconnect kept");
  ack_atn_set_a: assert property (
    ctl_wr_s ##0 (reg_wdata[7:6] == 2'h3 && !reg_wdata[SMX_CTL_TARGET])
    |-> ##1 (ack_line_out && atn_line_out))
    else $error("ack atn missing");
  atn_drop_a: assert property (ctl_wr_s ##0 !reg_wdata[SMX_CTL_ATN] |-> ##1 !atn_line_out)
    else $error("atn kept");
  fetch_hold_a: assert property (
    fetch_req && !fetch_valid |=> fetch_req && $stable(fetch_addr))
    else $error("fetch moved");
endmodule : smx_exec_checker
bind smx_exec smx_exec_checker i_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fetch_valid(fetch_valid), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .arb_won_in(arb_won_in), .msg_line_out(msg_line_out), .cd_line_out(cd_line_out),
  .io_line_out(io_line_out), .ack_line_out(ack_line_out), .atn_line_out(atn_line_out),
  .drive_oe(drive_oe), .arb_req(arb_req), .arb_dest(arb_dest));
`default_nettype wire

// >>> sim/smx_peer.sv
// partner model: other scsi devices on the bus
`timescale 1ns/1ns
`default_nettype none
module smx_peer (
  // clock and scenario control
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic conn,
  input wire logic [2:0] ph,
  // bus as seen by the executor
  output logic [2:0] phase,
  output logic req,
  output logic connected,
  output logic selected,
  output logic reselected,
  output logic won,
  output logic lost
);
  int n = 0;
  always @(posedge clk) begin
    n <= (mode == 2'h0) ? 0 : n + 1;
  end
  // released lines show the inverse, never a stale phase
  assign phase = conn ? ph : ~ph;
  assign req = conn;
  assign connected = conn;
  // first attempt lost, a later one won: the executor has to retry
  assign lost = mode == 2'h1 && n > 4 && n < 8;
  assign won = mode == 2'h1 && n > 14;
  assign selected = mode == 2'h2 && n > 4;
  assign reselected = mode == 2'h3 && n > 4;
endmodule : smx_peer
`default_nettype wire

// >>> sim/tb_smx_exec.sv
// testbench for the move and io executor
`timescale 1ns/1ns
`default_nettype none
module tb_smx_exec;
  import smx_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic wr_s = 1'b0, rd_s = 1'b0, bstb = 1'b0, wide = 1'b0, fv = 1'b0, conn = 1'b0;
  logic [7:0] bdat = 8'h0;
  logic [31:0] fd = 32'h0;
  logic [1:0] mode = 2'h0;
  logic [2:0] ph = 3'h0;
  logic [31:0] rdat, fa, v;
  logic [31:0] ctl_m = 32'h0;
  logic [31:0] faq[$];
  logic [7:0] lastb;
  logic [2:0] phs, bp;
  logic rq, con, sel, rsel, won, lost, fr, mo, co, io, ack, atn, oe, arq, a;
  logic [3:0] adst;
  logic [1:0] md [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
  int miscompares = 0, samples_checked = 0, n, p;
  always #25 clk = ~clk;
  smx_exec i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .fetch_valid(fv), .fetch_data(fd),
    .fetch_req(fr), .fetch_addr(fa), .byte_stb(bstb), .byte_data(bdat), .wide(wide),
    .parity_err(1'b0), .msg_line_in(phs[2]), .cd_line_in(phs[1]), .io_line_in(phs[0]),
    .req_line_in(rq), .ack_line_in(1'b0), .atn_line_in(1'b0), .connected_in(con),
    .selected_in(sel), .reselected_in(rsel), .arb_won_in(won), .arb_lost_in(lost),
    .msg_line_out(mo), .cd_line_out(co), .io_line_out(io), .ack_line_out(ack),
    .atn_line_out(atn), .drive_oe(oe), .arb_req(arq), .arb_dest(adst));
  smx_peer i_peer (.clk(clk), .mode(mode), .conn(conn), .ph(ph), .phase(phs), .req(rq),
    .connected(con), .selected(sel), .reselected(rsel), .won(won), .lost(lost));
  always @(posedge clk) begin
    fv <= fr && !fv;
    fd <= fa[2] ? 32'h0000_2000 : 32'h2;
    if (fr && !fv) faq.push_back(fa);
  end
  // ****************
  // bench model and bus tasks
  // ****************
  function automatic int cdb_len(input int g, input bit vue, input int prog);
    case (g)
      0: return 6;
      1, 2: return 10;
      5: return 12;
      6, 7: return vue ? prog : 6;
      default: return prog;
    endcase
  endfunction : cdb_len
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    ra <= ad;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [31:0] d);
    ra <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdat;
    @(posedge clk);
  endtask : rd
  task automatic poll(input int b, input logic e);
    logic f = 1'b0;
    for (int i = 0; i < 12 && !f; i++) begin
      rd(SMX_ADDR_STATUS, v);
      f = v[b];
    end
    chk({31'h0, f}, {31'h0, e});
  endtask : poll
  task automatic run(input logic [31:0] c, input logic [1:0] m);
    wr(SMX_ADDR_STATUS, 32'hff);
    wr(SMX_ADDR_CMD, c);
    wr(SMX_ADDR_CTRL, ctl_m | 32'h1);
    mode <= m;
    repeat (2) @(posedge clk);
  endtask : run
  task automatic send(input int k, input logic [7:0] b0);
    repeat (k) begin
      bdat <= b0;
      lastb = b0;
      bstb <= 1'b1;
      @(posedge clk);
      bstb <= 1'b0;
      b0 = 8'($urandom);
      @(posedge clk);
    end
  endtask : send
  task automatic ctl_is(input logic [1:0] pins);
    rd(SMX_ADDR_CTRL, v);
    chk(v & 32'hff, ctl_m);
    chk({30'h0, ack, atn}, {30'h0, pins});
  endtask : ctl_is
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #3_000_000;
    miscompares++;
    tally_and_finish();
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    void'($urandom(32'h43e14444));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(SMX_ADDR_STATUS, v);
    chk(v, 32'h0);
    rd(4'hf, v);
    chk(v, 32'h0);
    run(32'h5800_0448, 2'h0);
    poll(SMX_ST_FETCH, 1'b1);
    ctl_m = 32'he0;
    ctl_is(2'h3);
    run(32'h5800_0200, 2'h0);
    poll(SMX_ST_FETCH, 1'b1);
    ctl_m = 32'he8;
    ctl_is(2'h0);
    run(32'h6000_0448, 2'h0);
    poll(SMX_ST_FETCH, 1'b1);
    ctl_m = 32'h08;
    ctl_is(2'h0);
    run(32'h0000_0004, 2'h0);
    send(4, 8'h00);
    poll(SMX_ST_FETCH, 1'b0);
    conn <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      p = (k == 3) ? 0 : 2 + $urandom % 13;
      ctl_m[SMX_CTL_VUE] = k[3];
      n = cdb_len(k % 8, k[3], p);
      run(32'h0200_0000 | p, 2'h0);
      send(n > 0 ? n - 1 : 1, {k[2:0], 5'($urandom)});
      if (n == 0) begin
        poll(SMX_ST_FETCH, 1'b0);
      end else begin
        chk({28'h0, oe, mo, co, io}, 32'ha);
        poll(SMX_ST_FETCH, 1'b0);
        send(1, 8'($urandom));
        poll(SMX_ST_FETCH, 1'b1);
      end
    end
    ctl_m[SMX_CTL_VUE] = 1'b0;
    wide <= 1'b1;
    run(32'h0800_0003, 2'h0);
    send(3, 8'($urandom));
    poll(SMX_ST_FETCH, 1'b1);
    rd(SMX_ADDR_RESID, v);
    chk(v & 32'hff, {24'h0, lastb});
    wide <= 1'b0;
    wr(SMX_ADDR_BASE, 32'h100);
    wr(SMX_ADDR_ARG, 32'h00ff_fff8);
    faq.delete();
    run(32'h1000_0000, 2'h0);
    repeat (8) @(posedge clk);
    send(2, 8'h11);
    poll(SMX_ST_FETCH, 1'b1);
    chk(faq[0], 32'hf8);
    chk(faq[1], 32'hfc);
    ctl_m[SMX_CTL_TARGET] = 1'b0;
    bp = 3'($urandom);
    ph <= bp;
    for (int q = 0; q < 8; q++) begin
      run(32'h0800_0001 | (q << 24), 2'h0);
      if (q == bp) send(1, 8'($urandom));
      poll(SMX_ST_FETCH, q == bp);
      rd(SMX_ADDR_STATUS, v);
      chk(v & 32'h7, {29'h0, bp});
    end
    chk({31'h0, ack}, {31'h0, bp == 3'h7});
    ctl_m[SMX_CTL_TARGET] = 1'b1;
    for (int k = 0; k < 5; k++) begin
      a = (k % 2 == 1) || k == 4;
      run((k < 2 ? 32'h4000_0000 : 32'h5000_0000) | (($urandom % 16) << 16), md[k]);
      if (k == 4) wr(SMX_ADDR_CTRL, ctl_m | 32'h10);
      poll(a ? SMX_ST_ALT : SMX_ST_FETCH, 1'b1);
      rd(SMX_ADDR_STATUS, v);
      chk({31'h0, v[SMX_ST_ALT]}, {31'h0, a});
      mode <= 2'h0;
    end
    run(32'h4800_0000, 2'h0);
    poll(SMX_ST_FETCH, 1'b1);
    chk({28'h0, oe, ack, atn, arq}, 32'h0);
    tally_and_finish();
  end
endmodule : tb_smx_exec
`default_nettype wire
